// ===== hdl/iwsc_pin_drv.sv
/*
  Output stage of one multifunction pin: turns an active level into pin
  output and output enable for the selected drive mode.
  Assumes the pad resolves the wire from out and oe.
*/
`timescale 1ns/1ps
`default_nettype none
module iwsc_pin_drv
  import iwsc_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_B,
  // Pin request
  input  wire logic       level,
  input  wire iwsc_drv_t  mode,
  // Pad
  output var  logic       pin_out,
  output var  logic       pin_oe
);
  logic next_out;
  logic next_oe;

  always_comb begin
    case (mode)
      IWSC_DRV_LOW: begin
        next_out = ~level;
        next_oe  = 1'b1;
      end
      IWSC_DRV_OD_UP: begin
        next_out = 1'b1;
        next_oe  = level;
      end
      IWSC_DRV_OD_DN: begin
        next_out = 1'b0;
        next_oe  = level;
      end
      default: begin
        next_out = level;
        next_oe  = 1'b1;
      end
    endcase
  end

  // Default push-pull drives low from reset so the pin never floats.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b1;
    end else begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end
endmodule // iwsc_pin_drv
`default_nettype wire

// ===== hdl/iwsc_top.sv
/*
  Interrupt, watchdog and system clock control core: event latching and
  masking, pin routing, watchdog, multiplier stability and calibration.
  Assumes the serial port delivers one-cycle byte read and write strobes on CLK.
*/
// How it works
// - masked-in events latch monitor bits until cleared
// - writing one to clear byte clears bits
// - clear-all bit clears every monitor bit
// - masks reset to zero, no interrupts
// - per-pin drive: high, low, open-drain up/down
// - five groups: common plus four loops
// - groups on own pins or combined pin
// - watchdog off at reset, two config bytes
// - watchdog raises event each period expiry
// - clear-watchdog bit restarts count from zero
// - watchdog pin pulse lasts 40 ns
// - stable after lock held for stability time
// - update write applies all buffered settings
// - calibration bit set from clear arms multiplier calibration on update
// - calibrate-all with update recalibrates all loops
// - monitor readback valid only while locked
// - loop calibration, reference monitoring wait stable
// - stable condition readable in status bit
`timescale 1ns/1ps
`default_nettype none
module iwsc_top
  import iwsc_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                     CLK,
  input  wire logic                     RST_B,
  // Register port
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  input  wire logic [15:0]              REG_ADDR,
  input  wire logic [7:0]               REG_WDATA,
  output var  logic [7:0]               REG_RDATA,
  // Events and multiplier
  input  wire logic [NUM_EV_BYTES*8-1:0] EVENTS,
  input  wire logic                     MULT_LOCKED,
  // Multifunction pins
  output var  logic [NUM_PINS-1:0]      MFP_OUT,
  output var  logic [NUM_PINS-1:0]      MFP_OE,
  // Control outputs
  output var  logic                     UPDATE_PULSE,
  output var  logic                     MULT_CAL_START,
  output var  logic                     LOOP_CAL_ALL,
  output var  logic                     LOOP_CAL_ENABLE,
  output var  logic                     REF_MON_ENABLE,
  output var  logic                     SYS_STABLE,
  output var  logic [7:0]               REF_POWER_DOWN
);
  import iwsc_pkg::*;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] b,
                                  input int n);
    in_rng = (a >= b) && (a < b + 16'(n));
  endfunction

  function automatic int idx(input logic [15:0] a, input logic [15:0] b);
    idx = int'(a - b);
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0]  mask_buf [NUM_EV_BYTES];
  logic [7:0]  mask_act [NUM_EV_BYTES];
  logic [7:0]  mon      [NUM_EV_BYTES];
  logic [2:0]  fn_buf   [NUM_PINS];
  logic [2:0]  fn_act   [NUM_PINS];
  logic [1:0]  md_buf   [NUM_PINS];
  logic [1:0]  md_act   [NUM_PINS];
  logic [15:0] wd_buf, wd_act, stab_buf, stab_act;
  logic [7:0]  cal_buf, cal_act, pd_buf;
  logic        upd, wd_clr, cal_pend, mult_cal;
  logic [7:0]  next_mask_buf [NUM_EV_BYTES];
  logic [7:0]  next_mask_act [NUM_EV_BYTES];
  logic [7:0]  next_mon      [NUM_EV_BYTES];
  logic [2:0]  next_fn_buf   [NUM_PINS];
  logic [2:0]  next_fn_act   [NUM_PINS];
  logic [1:0]  next_md_buf   [NUM_PINS];
  logic [1:0]  next_md_act   [NUM_PINS];
  logic [15:0] next_wd_buf, next_wd_act, next_stab_buf, next_stab_act;
  logic [7:0]  next_cal_buf, next_cal_act, next_pd_buf, next_pd_act, next_rdata;
  logic        next_upd, next_wd_clr, next_cal_pend, next_mult_cal, next_cal_all;
  logic [NUM_EV_BYTES*8-1:0] ev;
  logic [NUM_GROUPS-1:0]     grp_irq;
  logic [NUM_PINS-1:0]       pin_lvl;
  logic                      any_irq;

  // ---------------------------------------------------------------------------
  // Lock synchroniser, millisecond divider and stability timer
  // ---------------------------------------------------------------------------
  logic        lk1, lk2, lk3, locked, next_locked;
  logic [31:0] div, next_div;
  logic        ms_tick, next_ms_tick;
  logic [15:0] stab_cnt, next_stab_cnt;
  logic        next_stable;

  always_comb begin
    next_locked   = (lk2 == lk3) ? lk3 : locked;
    next_ms_tick  = (div == 32'(CYC_MS - 1));
    next_div      = next_ms_tick ? 32'h0000_0000 : div + 32'h0000_0001;
    next_stab_cnt = stab_cnt;
    if (!locked) begin
      next_stab_cnt = 16'h0000;
    end else if (ms_tick && stab_cnt < stab_act) begin
      next_stab_cnt = stab_cnt + 16'd1;
    end
    next_stable = locked && (stab_cnt >= stab_act);
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lk1        <= 1'b0;
      lk2        <= 1'b0;
      lk3        <= 1'b0;
      locked     <= 1'b0;
      div        <= 32'h0000_0000;
      ms_tick    <= 1'b0;
      stab_cnt   <= 16'h0000;
      SYS_STABLE <= 1'b0;
    end else begin
      lk1        <= MULT_LOCKED;
      lk2        <= lk1;
      lk3        <= lk2;
      locked     <= next_locked;
      div        <= next_div;
      ms_tick    <= next_ms_tick;
      stab_cnt   <= next_stab_cnt;
      SYS_STABLE <= next_stable;
    end
  end

  // ---------------------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------------------
  iwsc_wd_if wdc ();
  assign wdc.period  = wd_act;
  assign wdc.ms_tick = ms_tick;
  assign wdc.restart = wd_clr;

  iwsc_watchdog u_wd (
    .CLK   (CLK),
    .RST_B (RST_B),
    .wd    (wdc.tmr)
  );

  // ---------------------------------------------------------------------------
  // Interrupt groups and pin routing
  // ---------------------------------------------------------------------------
  always_comb begin
    ev = EVENTS;
    ev[WD_EVENT_BIT] = EVENTS[WD_EVENT_BIT] | wdc.expire;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      grp_irq[g] = 1'b0;
      for (int b = 0; b < BYTES_PER_GROUP; b++) begin
        grp_irq[g] = grp_irq[g] | (|mon[g*BYTES_PER_GROUP+b]);
      end
    end
    any_irq = |grp_irq;
    for (int p = 0; p < NUM_PINS; p++) begin
      case (iwsc_pin_fn_t'(fn_act[p]))
        IWSC_FN_IRQ:    pin_lvl[p] = grp_irq[p];
        IWSC_FN_IRQALL: pin_lvl[p] = any_irq;
        IWSC_FN_WD:     pin_lvl[p] = wdc.pulse;
        IWSC_FN_STABLE: pin_lvl[p] = SYS_STABLE;
        default:        pin_lvl[p] = 1'b0;
      endcase
    end
  end

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    iwsc_pin_drv u_drv (
      .CLK     (CLK),
      .RST_B   (RST_B),
      .level   (pin_lvl[p]),
      .mode    (iwsc_drv_t'(md_act[p])),
      .pin_out (MFP_OUT[p]),
      .pin_oe  (MFP_OE[p])
    );
  end

  // ---------------------------------------------------------------------------
  // Register writes, update transfer, event latching and readback
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [7:0] clr [NUM_EV_BYTES];
    for (int i = 0; i < NUM_EV_BYTES; i++) begin
      clr[i]           = 8'h00;
      next_mask_buf[i] = mask_buf[i];
      next_mask_act[i] = upd ? mask_buf[i] : mask_act[i];
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      next_fn_buf[p] = fn_buf[p];
      next_md_buf[p] = md_buf[p];
      next_fn_act[p] = upd ? fn_buf[p] : fn_act[p];
      next_md_act[p] = upd ? md_buf[p] : md_act[p];
    end
    next_wd_buf   = wd_buf;
    next_stab_buf = stab_buf;
    next_cal_buf  = cal_buf;
    next_pd_buf   = pd_buf;
    next_wd_act   = upd ? wd_buf : wd_act;
    next_stab_act = upd ? stab_buf : stab_act;
    next_cal_act  = upd ? cal_buf : cal_act;
    next_pd_act   = upd ? pd_buf : REF_POWER_DOWN;
    next_upd      = 1'b0;
    next_wd_clr   = 1'b0;
    // Both calibration paths start the multiplier; calibrate-all also
    // restarts the loops once the clock is stable.
    next_mult_cal = upd && ((cal_buf[CAL_MULT_BIT] && !cal_act[CAL_MULT_BIT])
                    || cal_buf[CAL_ALL_BIT]);
    next_cal_pend = cal_pend | (upd && cal_buf[CAL_ALL_BIT]);
    next_cal_all  = 1'b0;
    if (next_cal_pend && SYS_STABLE) begin
      next_cal_all  = 1'b1;
      next_cal_pend = 1'b0;
    end
    if (REG_WR) begin
      if (REG_ADDR == ADR_UPDATE) begin
        next_upd = (REG_WDATA == UPDATE_CODE);
      end else if (in_rng(REG_ADDR, ADR_MASK, NUM_EV_BYTES)) begin
        next_mask_buf[idx(REG_ADDR, ADR_MASK)] = REG_WDATA;
      end else if (in_rng(REG_ADDR, ADR_PIN_FUNC, NUM_PINS)) begin
        next_fn_buf[idx(REG_ADDR, ADR_PIN_FUNC)] = REG_WDATA[2:0];
      end else if (in_rng(REG_ADDR, ADR_PIN_MODE, NUM_PINS)) begin
        next_md_buf[idx(REG_ADDR, ADR_PIN_MODE)] = REG_WDATA[1:0];
      end else if (REG_ADDR == ADR_WD_LOW) begin
        next_wd_buf[7:0] = REG_WDATA;
      end else if (REG_ADDR == ADR_WD_HIGH) begin
        next_wd_buf[15:8] = REG_WDATA;
      end else if (REG_ADDR == ADR_STAB_LOW) begin
        next_stab_buf[7:0] = REG_WDATA;
      end else if (REG_ADDR == ADR_STAB_HIGH) begin
        next_stab_buf[15:8] = REG_WDATA;
      end else if (REG_ADDR == ADR_CAL_CTRL) begin
        next_cal_buf = REG_WDATA;
      end else if (REG_ADDR == ADR_REF_PD) begin
        next_pd_buf = REG_WDATA;
      end else if (REG_ADDR == ADR_CLR_COMMON) begin
        next_wd_clr = REG_WDATA[CLR_WD_BIT];
        for (int i = 0; i < NUM_EV_BYTES; i++) begin
          clr[i] = {8{REG_WDATA[CLR_ALL_BIT]}};
        end
      end else if (in_rng(REG_ADDR, ADR_CLR_BYTE, NUM_EV_BYTES)) begin
        clr[idx(REG_ADDR, ADR_CLR_BYTE)] = REG_WDATA;
      end
    end
    // A new event wins over a clear in the same cycle.
    for (int i = 0; i < NUM_EV_BYTES; i++) begin
      next_mon[i] = (mon[i] & ~clr[i]) | (ev[i*8 +: 8] & mask_act[i]);
    end
    next_rdata = 8'h00;
    if (REG_ADDR == ADR_STATUS) begin
      next_rdata[ST_LOCKED_BIT] = locked;
      next_rdata[ST_STABLE_BIT] = SYS_STABLE;
    end else if (in_rng(REG_ADDR, ADR_MONITOR, NUM_EV_BYTES)) begin
      // Monitor state lives on the multiplier's clock in silicon, so it is
      // withheld while that clock is unlocked.
      next_rdata = locked ? mon[idx(REG_ADDR, ADR_MONITOR)] : 8'h00;
    end else if (in_rng(REG_ADDR, ADR_MASK, NUM_EV_BYTES)) begin
      next_rdata = mask_buf[idx(REG_ADDR, ADR_MASK)];
    end else if (in_rng(REG_ADDR, ADR_PIN_FUNC, NUM_PINS)) begin
      next_rdata = {5'h00, fn_buf[idx(REG_ADDR, ADR_PIN_FUNC)]};
    end else if (in_rng(REG_ADDR, ADR_PIN_MODE, NUM_PINS)) begin
      next_rdata = {6'h00, md_buf[idx(REG_ADDR, ADR_PIN_MODE)]};
    end else if (REG_ADDR == ADR_WD_LOW) begin
      next_rdata = wd_buf[7:0];
    end else if (REG_ADDR == ADR_WD_HIGH) begin
      next_rdata = wd_buf[15:8];
    end else if (REG_ADDR == ADR_STAB_LOW) begin
      next_rdata = stab_buf[7:0];
    end else if (REG_ADDR == ADR_STAB_HIGH) begin
      next_rdata = stab_buf[15:8];
    end else if (REG_ADDR == ADR_CAL_CTRL) begin
      next_rdata = cal_buf;
    end else if (REG_ADDR == ADR_REF_PD) begin
      next_rdata = pd_buf;
    end
    if (!REG_RD) begin
      next_rdata = REG_RDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NUM_EV_BYTES; i++) begin
        mask_buf[i] <= MASK_RESET;
        mask_act[i] <= MASK_RESET;
        mon[i]      <= 8'h00;
      end
      for (int p = 0; p < NUM_PINS; p++) begin
        fn_buf[p] <= IWSC_FN_OFF;
        fn_act[p] <= IWSC_FN_OFF;
        md_buf[p] <= IWSC_DRV_HIGH;
        md_act[p] <= IWSC_DRV_HIGH;
      end
      wd_buf         <= WD_RESET;
      wd_act         <= WD_RESET;
      stab_buf       <= STAB_RESET_MS;
      stab_act       <= STAB_RESET_MS;
      cal_buf        <= 8'h00;
      cal_act        <= 8'h00;
      pd_buf         <= 8'h00;
      REF_POWER_DOWN <= 8'h00;
      upd            <= 1'b0;
      wd_clr         <= 1'b0;
      cal_pend       <= 1'b0;
      REG_RDATA      <= 8'h00;
      UPDATE_PULSE   <= 1'b0;
      MULT_CAL_START <= 1'b0;
      LOOP_CAL_ALL   <= 1'b0;
      LOOP_CAL_ENABLE <= 1'b0;
      REF_MON_ENABLE <= 1'b0;
    end else begin
      mask_buf       <= next_mask_buf;
      mask_act       <= next_mask_act;
      mon            <= next_mon;
      fn_buf         <= next_fn_buf;
      fn_act         <= next_fn_act;
      md_buf         <= next_md_buf;
      md_act         <= next_md_act;
      wd_buf         <= next_wd_buf;
      wd_act         <= next_wd_act;
      stab_buf       <= next_stab_buf;
      stab_act       <= next_stab_act;
      cal_buf        <= next_cal_buf;
      cal_act        <= next_cal_act;
      pd_buf         <= next_pd_buf;
      REF_POWER_DOWN <= next_pd_act;
      upd            <= next_upd;
      wd_clr         <= next_wd_clr;
      cal_pend       <= next_cal_pend;
      REG_RDATA      <= next_rdata;
      UPDATE_PULSE   <= upd;
      MULT_CAL_START <= next_mult_cal;
      LOOP_CAL_ALL   <= next_cal_all;
      LOOP_CAL_ENABLE <= next_stable;
      REF_MON_ENABLE <= next_stable;
    end
  end
endmodule // iwsc_top
`default_nettype wire

// ===== hdl/iwsc_watchdog.sv
/*
  Watchdog timer: counts millisecond ticks up to the programmed period and
  reports each expiry as an event and as a short pin pulse.
  Assumes ms_tick is a one-cycle enable from the core's divider.
*/
`timescale 1ns/1ps
`default_nettype none
module iwsc_watchdog
  import iwsc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Timer carrier
  iwsc_wd_if.tmr   wd
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [1:0]  pcnt;
  logic [1:0]  next_pcnt;
  logic        next_expire;

  always_comb begin
    next_cnt    = cnt;
    next_pcnt   = (pcnt != 2'd0) ? pcnt - 2'd1 : 2'd0;
    next_expire = 1'b0;
    if (wd.restart || wd.period == WD_RESET) begin
      next_cnt = 16'h0000;
    end else if (wd.ms_tick) begin
      if (cnt >= wd.period - 16'd1) begin
        next_cnt    = 16'h0000;
        next_expire = 1'b1;
        next_pcnt   = 2'(WD_PULSE_CYC);
      end else begin
        next_cnt = cnt + 16'd1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt       <= 16'h0000;
      pcnt      <= 2'd0;
      wd.expire <= 1'b0;
      wd.pulse  <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      pcnt      <= next_pcnt;
      wd.expire <= next_expire;
      wd.pulse  <= (next_pcnt != 2'd0);
    end
  end
endmodule // iwsc_watchdog
`default_nettype wire

// ===== pkg/iwsc_pkg.sv
/*
  Shared constants of the interrupt, watchdog and system clock control block:
  register offsets, field positions, reset values, pin modes and timing counts.
  Assumes a single 50 MHz core clock for every block that imports it.
*/
`default_nettype none
package iwsc_pkg;
  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [15:0] ADR_UPDATE      = 16'h000F;
  localparam logic [15:0] ADR_PIN_FUNC    = 16'h0100;
  localparam logic [15:0] ADR_PIN_MODE    = 16'h0105;
  localparam logic [15:0] ADR_WD_LOW      = 16'h010D;
  localparam logic [15:0] ADR_WD_HIGH     = 16'h010E;
  localparam logic [15:0] ADR_MASK        = 16'h010F;
  localparam logic [15:0] ADR_STAB_LOW    = 16'h0206;
  localparam logic [15:0] ADR_STAB_HIGH   = 16'h0207;
  localparam logic [15:0] ADR_CAL_CTRL    = 16'h0A00;
  localparam logic [15:0] ADR_REF_PD      = 16'h0A01;
  localparam logic [15:0] ADR_CLR_COMMON  = 16'h0A05;
  localparam logic [15:0] ADR_CLR_BYTE    = 16'h0A06;
  localparam logic [15:0] ADR_STATUS      = 16'h0D01;
  localparam logic [15:0] ADR_MONITOR     = 16'h0D08;
  // ---------------------------------------------------------------------------
  // Sizes, fields and reset values
  // ---------------------------------------------------------------------------
  localparam int          NUM_GROUPS      = 5;
  localparam int          BYTES_PER_GROUP = 3;
  localparam int          NUM_EV_BYTES    = 15;
  localparam int          NUM_PINS        = 5;
  localparam logic [7:0]  UPDATE_CODE     = 8'h01;
  localparam int          CLR_ALL_BIT     = 0;
  localparam int          CLR_WD_BIT      = 7;
  localparam int          CAL_ALL_BIT     = 1;
  localparam int          CAL_MULT_BIT    = 2;
  localparam int          ST_LOCKED_BIT   = 0;
  localparam int          ST_STABLE_BIT   = 1;
  localparam int          WD_EVENT_BIT    = 0;
  localparam logic [7:0]  MASK_RESET      = 8'h00;
  localparam logic [15:0] WD_RESET        = 16'h0000;
  localparam logic [15:0] STAB_RESET_MS   = 16'h0032;
  // ---------------------------------------------------------------------------
  // Pin functions and drive modes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    IWSC_FN_OFF    = 3'h0,
    IWSC_FN_IRQ    = 3'h1,
    IWSC_FN_IRQALL = 3'h2,
    IWSC_FN_WD     = 3'h3,
    IWSC_FN_STABLE = 3'h4
  } iwsc_pin_fn_t;
  typedef enum logic [1:0] {
    IWSC_DRV_HIGH  = 2'h0,
    IWSC_DRV_LOW   = 2'h1,
    IWSC_DRV_OD_UP = 2'h2,
    IWSC_DRV_OD_DN = 2'h3
  } iwsc_drv_t;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int WD_PULSE_NS   = 40;
  localparam int WD_PULSE_CYC  = (WD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_NS         = 1000000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ===== pkg/iwsc_wd_if.sv
/*
  Carrier between the control core and the watchdog timer.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface iwsc_wd_if;
  logic [15:0] period;
  logic        ms_tick;
  logic        restart;
  logic        expire;
  logic        pulse;
  modport ctl (output period, output ms_tick, output restart, input expire, input pulse);
  modport tmr (input period, input ms_tick, input restart, output expire, output pulse);
endinterface
`default_nettype wire

// ===== verification/iwsc_host_model.sv
/* Host on the register port: byte writes, reads, update and start-up wait.
   Assumes the core samples its strobes on the rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module iwsc_host_model
  import iwsc_pkg::*;
#(
  parameter int CYC_MS = 10
) (
  // Register port
  input  wire logic        CLK,
  input  wire logic [7:0]  REG_RDATA,
  output var  logic        REG_WR,
  output var  logic        REG_RD,
  output var  logic [15:0] REG_ADDR,
  output var  logic [7:0]  REG_WDATA
);
  initial begin
    REG_WR = 1'h0;
    REG_RD = 1'h0;
    REG_ADDR = 16'h0000;
    REG_WDATA = 8'h00;
  end
  task automatic boot();
    repeat (25 * CYC_MS) @(posedge CLK);
  endtask
  // Released lines show the inverse value so stale data is never trusted.
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge CLK);
    REG_WR <= 1'h1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge CLK);
    REG_WR <= 1'h0;
    REG_ADDR <= ~a;
    REG_WDATA <= ~v;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge CLK);
    REG_RD <= 1'h1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'h0;
    REG_ADDR <= ~a;
    #1 v = REG_RDATA;
  endtask
  task automatic upd();
    wr(ADR_UPDATE, UPDATE_CODE);
  endtask
  task automatic cal(input logic [7:0] v);
    wr(ADR_CAL_CTRL, v | 8'h04);
    upd();
  endtask
endmodule // iwsc_host_model
`default_nettype wire

// ===== verification/iwsc_properties.sv
/* Port checker for iwsc_top: update, calibration and stability timing.
   Assumes it is bound to iwsc_top and shares its clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module iwsc_properties
  import iwsc_pkg::*;
(
  // Clock, reset and register port
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [7:0]  REG_RDATA,
  // Multiplier and controls
  input wire logic        MULT_LOCKED,
  input wire logic        UPDATE_PULSE,
  input wire logic        MULT_CAL_START,
  input wire logic        LOOP_CAL_ALL,
  input wire logic        LOOP_CAL_ENABLE,
  input wire logic        REF_MON_ENABLE,
  input wire logic        SYS_STABLE
);
  wire upd_wr = REG_WR && REG_ADDR == ADR_UPDATE && REG_WDATA == UPDATE_CODE;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // Six cycles cover the lock synchroniser and the status register.
  sequence s_unlocked;
    !MULT_LOCKED [*6];
  endsequence
  sequence s_mon_rd;
    REG_RD && REG_ADDR >= ADR_MONITOR && REG_ADDR <= 16'h0D16;
  endsequence
  a_update_applies: assert property (upd_wr |-> ##2 UPDATE_PULSE)
    else $error("no update pulse");
  a_update_cause: assert property (UPDATE_PULSE |-> $past(upd_wr, 2))
    else $error("update pulse without write");
  a_update_single: assert property (UPDATE_PULSE && !$past(upd_wr) |=> !UPDATE_PULSE)
    else $error("update pulse too long");
  a_stable_lock: assert property (s_unlocked |-> !SYS_STABLE)
    else $error("stable while unlocked");
  a_gates_follow: assert property (LOOP_CAL_ENABLE == SYS_STABLE && REF_MON_ENABLE == SYS_STABLE)
    else $error("enable differs from stable");
  a_calall_gated: assert property (LOOP_CAL_ALL |-> $past(SYS_STABLE))
    else $error("loop calibration before stable");
  a_cal_on_update: assert property (MULT_CAL_START |-> UPDATE_PULSE)
    else $error("calibration without update");
  a_monitor_dark: assert property (s_unlocked ##0 s_mon_rd |=> REG_RDATA == 8'h00)
    else $error("monitor read while unlocked");
  a_status_stable: assert property (REG_RD && REG_ADDR == ADR_STATUS |=>
    REG_RDATA[ST_STABLE_BIT] == $past(SYS_STABLE))
    else $error("status stable bit wrong");
endmodule // iwsc_properties
bind iwsc_top iwsc_properties u_props (.*);
`default_nettype wire

// ===== verification/tb_top.sv
/* Self-checking bench for iwsc_top driven through the host model.
   Assumes a 50 MHz clock and a shortened millisecond of ten cycles. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import iwsc_pkg::*;
  localparam int CMS = 10;
  typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;} iwsc_row_t;
  localparam iwsc_row_t ROWS [8] = '{'{ADR_MASK, 8'h02, 8'h02}, '{ADR_PIN_FUNC, 8'h01, 8'h01},
    '{16'h0101, 8'h02, 8'h02}, '{16'h0102, 8'h03, 8'h03}, '{ADR_WD_LOW, 8'h02, 8'h02},
    '{ADR_WD_HIGH, 8'h00, 8'h00}, '{ADR_REF_PD, 8'h05, 8'h05}, '{16'h0003, 8'h5A, 8'h00}};
  // Pin 0 as {driven high, driven} per drive mode, asserted and idle.
  localparam logic [7:0] ACT = 8'h77;
  localparam logic [7:0] IDLE = 8'h0D;
  logic clk, rst_b, locked, reg_wr, reg_rd, upd_p, mcal, lcal, lcal_en, rmon_en, stable;
  logic [119:0] events;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ref_pd, d;
  logic [4:0] mfp_out, mfp_oe;
  int n_errors, check_count, n_mcal, n_lcal, i, w, t0, cyc;
  iwsc_host_model #(.CYC_MS(CMS)) host (.CLK(clk), .REG_RDATA(reg_rdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata));
  iwsc_top #(.CYC_MS(CMS)) dut (.CLK(clk), .RST_B(rst_b), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .EVENTS(events),
    .MULT_LOCKED(locked), .MFP_OUT(mfp_out), .MFP_OE(mfp_oe), .UPDATE_PULSE(upd_p),
    .MULT_CAL_START(mcal), .LOOP_CAL_ALL(lcal), .LOOP_CAL_ENABLE(lcal_en),
    .REF_MON_ENABLE(rmon_en), .SYS_STABLE(stable), .REF_POWER_DOWN(ref_pd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      n_errors++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      print_verdict();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse();
    @(posedge clk);
    events <= 120'h6;
    @(posedge clk);
    events <= '0;
  endtask
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (mcal === 1'h1) n_mcal++;
    if (lcal === 1'h1) n_lcal++;
  end
  initial begin
    rst_b = 1'h0;
    locked = 1'h0;
    events = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    locked <= 1'h1;
    tick(1);
    t0 = cyc;
    chk({3'h0, mfp_oe}, 8'h1F);
    chk({3'h0, mfp_out}, 8'h00);
    host.boot();
    host.rd(ADR_MASK, d);
    chk(d, MASK_RESET);
    host.rd(ADR_WD_LOW, d);
    chk(d, WD_RESET[7:0]);
    foreach (ROWS[k]) begin
      host.wr(ROWS[k].a, ROWS[k].d);
      host.rd(ROWS[k].a, d);
      chk(d, ROWS[k].e);
    end
    chk(ref_pd, 8'h00);
    host.upd();
    tick(3);
    chk(ref_pd, 8'h05);
    chk({7'h0, stable}, 8'h00);
    for (i = 0; i < 600 && stable !== 1'h1; i++) tick(1);
    tmo(i, 600);
    chk(8'(cyc - t0 >= 49 * CMS && cyc - t0 <= 50 * CMS + 8), 8'h01);
    chk({5'h0, stable, lcal_en, rmon_en}, 8'h07);
    pulse();
    tick(3);
    chk({6'h0, mfp_out[1:0]}, 8'h03);
    host.rd(ADR_MONITOR, d);
    chk(d, 8'h02);
    host.wr(ADR_CLR_BYTE, 8'h02);
    host.rd(ADR_MONITOR, d);
    chk(d, 8'h00);
    chk({6'h0, mfp_out[1:0]}, 8'h00);
    for (i = 0; i < 4; i++) begin
      host.wr(ADR_PIN_MODE, 8'(i));
      host.upd();
      tick(3);
      chk({6'h0, mfp_out[0] & mfp_oe[0], mfp_oe[0]}, {6'h0, IDLE[2*i +: 2]});
      pulse();
      tick(3);
      chk({6'h0, mfp_out[0] & mfp_oe[0], mfp_oe[0]}, {6'h0, ACT[2*i +: 2]});
      host.wr(ADR_CLR_COMMON, 8'h01);
      host.rd(ADR_MONITOR, d);
      chk(d, 8'h00);
    end
    for (i = 0; i < 40 && mfp_out[2] !== 1'h0; i++) tick(1);
    for (i = 0; i < 40 && mfp_out[2] !== 1'h1; i++) tick(1);
    tmo(i, 40);
    for (w = 0; w < 9 && mfp_out[2] === 1'h1; w++) tick(1);
    chk(8'(w), 8'(WD_PULSE_CYC));
    for (i = w; i < 40 && mfp_out[2] !== 1'h1; i++) tick(1);
    chk(8'(i), 8'(2 * CMS));
    tick(8);
    host.wr(ADR_CLR_COMMON, 8'h80);
    tick(0);
    for (i = 0; i < 40 && mfp_out[2] !== 1'h1; i++) tick(1);
    chk(8'(i >= 11 && i <= 25), 8'h01);
    host.cal(8'h00);
    host.cal(8'h02);
    tick(6);
    chk(8'(n_mcal), 8'h02);
    chk(8'(n_lcal), 8'h01);
    host.rd(ADR_STATUS, d);
    chk(d & 8'h03, 8'h03);
    pulse();
    locked <= 1'h0;
    tick(8);
    chk({5'h0, stable, lcal_en, rmon_en}, 8'h00);
    host.rd(ADR_MONITOR, d);
    chk(d, 8'h00);
    host.rd(ADR_STATUS, d);
    chk(d & 8'h02, 8'h00);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
